// ---- bdm_pkg.sv ----
package bdm_pkg;
	// ==========================================================
	// Address geometry
	localparam int ADDR_W       = 12;
	localparam int OPND_W       = 8;
	localparam int BANK_W       = 4;
	localparam int DATA_W       = 8;
	localparam int MEM_BYTES    = 4096;
	localparam int NUM_BANKS    = 16;
	localparam int BANK_BYTES   = 256;

	// ==========================================================
	// Access window split and fixed banks
	localparam logic [7:0] WIN_SPLIT   = 8'h60;
	localparam logic [3:0] WIN_LO_BANK = 4'h0;
	localparam logic [3:0] WIN_HI_BANK = 4'hf;
	// Extended set: window split point moves up; low part grows
	localparam logic [7:0] XWIN_SPLIT  = 8'h80;

	// ==========================================================
	// Special register area and two fixed registers
	localparam logic [11:0] SFR_BASE     = 12'hdfa;
	localparam logic [11:0] PC_LOW_ADDR  = 12'hff9;
	localparam logic [11:0] BANK_PTR_ADDR = 12'he00;

	// ==========================================================
	// APB map (byte addresses)
	localparam logic [11:0] REG_BANK_PTR = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_CFG      = 12'h008;
	localparam logic [7:0]  BANK_PTR_RST = 8'h00;
	localparam logic [7:0]  BANK_PTR_MSK = 8'h0f;
endpackage

// ---- bdm_core.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] Data memory is a static RAM with a 12-bit byte address, 4096 bytes.
// [RQ2] Sixteen contiguous banks of 256 bytes; IMPL_BANKS sets how many are implemented here.
// [RQ3] Reads of unimplemented locations return zero.
// [RQ4] Banked address is bank pointer on top, operand below.
// [RQ5] Only bank pointer bits 3:0 exist; upper bits read zero, ignore writes.
// [RQ6] Load-bank-literal writes its literal straight into the bank pointer.
// [RQ7] Writes to unimplemented banks do nothing; reads give zero.
// [RQ8] Status flags update as usual even for unimplemented bank accesses.
// [RQ9] Full-address move uses two 12-bit addresses, ignoring bank pointer.
// [RQ10] Window: 00h-5Fh to bank 0, 60h-FFh to bank 15, same offsets.
// [RQ11] Access bit one uses bank pointer; zero uses window, pointer ignored.
// [RQ12] Window access completes in one cycle, no pointer update needed.
// [RQ13] Bank 0Fh with operand F9h selects the program counter low register.
// [RQ14] Extended set enable applies a modified window mapping.
// [RQ15] Special registers fill bank 15, bank 14 and top of bank 13.
// [RQ16] General RAM is not initialised by any reset.
// [RQ17] Bank pointer clears to zero on reset.
module bdm_core #(
	parameter int IMPL_BANKS = bdm_pkg::NUM_BANKS
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// Core execute port
	input  wire logic                        ex_valid,
	input  wire logic                        ex_write,
	input  wire logic                        ex_access_bit,
	input  wire logic                        ex_full_addr,
	input  wire logic [bdm_pkg::ADDR_W-1:0]  ex_full_src,
	input  wire logic [bdm_pkg::ADDR_W-1:0]  ex_full_dst,
	input  wire logic [bdm_pkg::OPND_W-1:0]  ex_operand,
	input  wire logic [bdm_pkg::DATA_W-1:0]  ex_wdata,
	input  wire logic                        ex_load_bank,
	input  wire logic [bdm_pkg::DATA_W-1:0]  ex_bank_literal,
	input  wire logic                        ex_status_upd,
	input  wire logic [4:0]                  ex_status_in,
	output logic      [bdm_pkg::DATA_W-1:0]  ex_rdata,
	output logic                             ex_rvalid,
	output logic      [bdm_pkg::ADDR_W-1:0]  ex_addr,
	output logic                             ex_pc_low_wr,
	output logic      [4:0]                  status_flags,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr
);
	import bdm_pkg::*;

	// ==========================================================
	// State
	// A full move needs a second cycle for its write; ST_MOVE marks it
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_MOVE = 2'b10
	} bdm_state_type;

	typedef struct packed {
		// Sequencer
		bdm_state_type             st;
		// Addressing state [RQ5] [RQ14]
		logic [BANK_W-1:0]         bank_ptr;
		logic                      ext_en;
		logic [ADDR_W-1:0]         mv_dst;
		// Execute answers
		logic [DATA_W-1:0]         rdata;
		logic                      rvalid;
		logic [ADDR_W-1:0]         addr;
		logic                      pc_wr;
		logic [4:0]                flags;
		// Bus answers
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
		// Accesses that hit an absent bank, except the write of a full move [RQ7]
		logic [7:0]                unimpl_cnt;
	} bdm_regs_type;

	bdm_regs_type r;
	bdm_regs_type r_nxt;

	// Data RAM: deliberately outside the reset struct so no reset
	// touches it [RQ1] [RQ16]
	// One flat array covers every bank; bank_ok trims it when fewer
	// banks are built [RQ2]
	logic [DATA_W-1:0] mem [MEM_BYTES];
	logic              mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [DATA_W-1:0] mem_wd;

	// ==========================================================
	// Address helpers
	function automatic logic [ADDR_W-1:0] win_addr(
		input logic [OPND_W-1:0] op,
		input logic              ext
	);
		logic [7:0] split;
		// Extended mode only moves the split point; indexed
		// remapping of the low part is not modelled here
		split = ext ? XWIN_SPLIT : WIN_SPLIT; // [RQ14]
		if (op < split)
			win_addr = {WIN_LO_BANK, op}; // [RQ10]
		else
			win_addr = {WIN_HI_BANK, op}; // [RQ10]
	endfunction

	function automatic logic bank_ok(input logic [ADDR_W-1:0] a);
		bank_ok = (32'(a[ADDR_W-1 -: BANK_W]) < IMPL_BANKS); // [RQ2] [RQ7]
	endfunction

	// Program counter low byte; a data write there is a jump, so the
	// core is told on a strobe of its own [RQ13]
	function automatic logic is_pc_low(input logic [ADDR_W-1:0] a);
		is_pc_low = (a == PC_LOW_ADDR); // [RQ13]
	endfunction

	// Register word shown to the bus master for an offset;
	// unmapped offsets read zero [RQ3]
	function automatic logic [31:0] apb_word(
		input logic [11:0]  a,
		input bdm_regs_type s
	);
		case (a)
			REG_BANK_PTR: apb_word = 32'(s.bank_ptr); // [RQ5]
			REG_STATUS:   apb_word = {16'h0, s.unimpl_cnt, 3'h0, s.flags};
			REG_CFG:      apb_word = 32'(s.ext_en); // [RQ14]
			default:      apb_word = '0; // [RQ3]
		endcase
	endfunction

	// Offsets that answer without an error
	function automatic logic apb_mapped(input logic [11:0] a);
		apb_mapped = (a == REG_BANK_PTR) || (a == REG_STATUS) ||
			(a == REG_CFG);
	endfunction

	// ==========================================================
	// Next-state logic
	// One pass per cycle: resolve the address, run the sequencer,
	// then serve the bus. The bus runs last so that its write to the
	// bank pointer wins over a load from the core in the same cycle.
	always_comb begin
		logic [ADDR_W-1:0] ea;
		logic              take;
		logic              apb_acc;
		logic              apb_done;
		ea       = '0;
		take     = 1'b0;
		apb_acc  = 1'b0;
		apb_done = 1'b0;
		r_nxt    = r;
		// RAM port idle unless a write is decoded below
		mem_we   = 1'b0;
		mem_wa   = '0;
		mem_wd   = '0;
		// One-cycle strobes drop unless raised again below
		r_nxt.rvalid  = 1'b0;
		r_nxt.pc_wr   = 1'b0;
		r_nxt.pready  = 1'b0;
		r_nxt.pslverr = 1'b0;

		// Banked or window address, resolved in the same cycle [RQ12]
		if (ex_access_bit)
			ea = {r.bank_ptr, ex_operand}; // [RQ4] [RQ11]
		else
			ea = win_addr(ex_operand, r.ext_en); // [RQ11]
		// The full move brings its own source address and never
		// consults the bank pointer, so it overrides both forms
		if (ex_full_addr)
			ea = ex_full_src; // [RQ9]
		// A bank pointer load is not a data access
		take = ex_valid && !ex_load_bank;

		case (r.st)
			// Accepts one request per cycle
			ST_IDLE: begin
				if (ex_valid && ex_load_bank) begin
					// Literal bits above the pointer are dropped
					r_nxt.bank_ptr = ex_bank_literal[BANK_W-1:0]; // [RQ5] [RQ6]
				end else if (take) begin
					r_nxt.addr = ea;
					// A full move always reads first, whatever the
					// direction bit says
					if (ex_write && !ex_full_addr) begin
						if (bank_ok(ea)) begin
							mem_we = 1'b1; // [RQ7]
							mem_wa = ea;
							mem_wd = ex_wdata;
						end else begin
							r_nxt.unimpl_cnt = r.unimpl_cnt + 8'h01;
						end
						r_nxt.pc_wr = is_pc_low(ea); // [RQ13] [RQ15]
					end else begin
						// Absent banks read as zero and are counted
						r_nxt.rvalid = 1'b1;
						r_nxt.rdata  = bank_ok(ea) ? mem[ea] : '0; // [RQ3] [RQ7]
						if (!bank_ok(ea))
							r_nxt.unimpl_cnt = r.unimpl_cnt + 8'h01;
					end
					if (ex_full_addr) begin
						r_nxt.mv_dst = ex_full_dst; // [RQ9]
						r_nxt.st     = ST_MOVE;
					end
				end
				// Flags follow the ALU even when the bank is absent [RQ8]
				if (ex_valid && ex_status_upd)
					r_nxt.flags = ex_status_in;
			end
			ST_MOVE: begin
				// Second word: store the byte read in the first [RQ9].
				// Requests in this cycle are not looked at; the core
				// spends it on the second instruction word.
				r_nxt.addr = r.mv_dst;
				if (bank_ok(r.mv_dst)) begin
					mem_we = 1'b1;
					mem_wa = r.mv_dst;
					mem_wd = r.rdata;
				end
				r_nxt.pc_wr = is_pc_low(r.mv_dst); // [RQ13]
				r_nxt.st = ST_IDLE;
			end
			default: r_nxt.st = ST_IDLE;
		endcase

		// APB access phase: the word is formed here and shown with
		// pready one cycle later, so the master reads a flop
		apb_acc  = psel && penable && !r.pready;
		// The edge that samples pready high completes the transfer; writes
		// land there and at no earlier edge
		apb_done = psel && penable && r.pready;
		if (apb_acc) begin
			r_nxt.pready  = 1'b1;
			r_nxt.prdata  = apb_word(paddr, r); // [RQ5]
			r_nxt.pslverr = !apb_mapped(paddr); // [RQ3]
		end
		// Upper pointer bits are never stored; an unmapped offset
		// takes no write
		if (apb_done && pwrite && apb_mapped(paddr)) begin
			if (paddr == REG_BANK_PTR)
				r_nxt.bank_ptr = pwdata[BANK_W-1:0]; // [RQ5]
			if (paddr == REG_CFG)
				r_nxt.ext_en = pwdata[0]; // [RQ14]
		end
	end

	// ==========================================================
	// Registers; bank pointer clears to zero [RQ17]
	// Every field is listed so a new one cannot slip in unreset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{
				st:         ST_IDLE,
				bank_ptr:   BANK_PTR_RST[BANK_W-1:0], // [RQ17]
				ext_en:     1'b0,
				mv_dst:     '0,
				rdata:      '0,
				rvalid:     1'b0,
				addr:       '0,
				pc_wr:      1'b0,
				flags:      '0,
				prdata:     '0,
				pready:     1'b0,
				pslverr:    1'b0,
				unimpl_cnt: '0
			};
		end else begin
			r <= r_nxt;
		end
	end

	// ==========================================================
	// RAM write port, no reset by design [RQ16]; a reset in mid-run
	// keeps every byte, so data survives it, and a read before the
	// first write gives an unknown byte in a model
	always_ff @(posedge core_clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	// ==========================================================
	// Outputs: each is a field of the state flop, so nothing
	// combinational reaches a pin
	// Execute side
	assign ex_rdata     = r.rdata;
	assign ex_rvalid    = r.rvalid;
	assign ex_addr      = r.addr;
	assign ex_pc_low_wr = r.pc_wr;
	assign status_flags = r.flags;
	// Bus side
	assign prdata       = r.prdata;
	assign pready       = r.pready;
	assign pslverr      = r.pslverr;
endmodule // bdm_core

// ---- bdm_core_chk.sv ----
`timescale 1ns/10ps
// ==========================================
// Port checks on the execute and APB sides
module bdm_core_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        ex_valid,
	input wire logic        ex_write,
	input wire logic        ex_access_bit,
	input wire logic        ex_full_addr,
	input wire logic        ex_load_bank,
	input wire logic [11:0] ex_full_src,
	input wire logic [7:0]  ex_operand,
	input wire logic        ex_status_upd,
	input wire logic [4:0]  ex_status_in,
	input wire logic        ex_rvalid,
	input wire logic [11:0] ex_addr,
	input wire logic        ex_pc_low_wr,
	input wire logic [4:0]  status_flags,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        pready
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Cycle after a full move is its write phase, not a request
	sequence s_take;
		ex_valid && !ex_load_bank && !$past(ex_valid && ex_full_addr);
	endsequence
	sequence s_win;
		s_take ##0 !ex_access_bit && !ex_full_addr;
	endsequence
	AST_WIN_LO: assert property (s_win ##0 ex_operand < 8'h60
		|=> ex_addr == {4'h0, $past(ex_operand)}) else $error("low window");
	AST_WIN_HI: assert property (s_win ##0 ex_operand >= 8'h80
		|=> ex_addr == {4'hf, $past(ex_operand)}) else $error("high window");
	AST_RVALID: assert property (s_take ##0 !ex_write && !ex_full_addr
		|=> ex_rvalid) else $error("read late");
	AST_PCLOW: assert property (ex_pc_low_wr |-> ex_addr == 12'hff9)
		else $error("pc low strobe");
	AST_FULL: assert property (s_take ##0 ex_full_addr
		|=> ex_addr == $past(ex_full_src)) else $error("full source");
	AST_FLAGS: assert property (s_take ##0 ex_status_upd
		|=> status_flags == $past(ex_status_in)) else $error("flags");
	AST_PRDY: assert property (psel && penable && !pready |=> pready) // APB
		else $error("apb late");
	AST_PULSE: assert property (pready |=> !pready) // APB
		else $error("pready held");
	AST_BANKED: assert property (s_take ##0 ex_access_bit
		##0 !ex_full_addr |=> ex_addr[7:0] == $past(ex_operand))
		else $error("banked low byte");
	AST_BANK_HI: assert property (pready && paddr == 12'h000
		|-> prdata[31:4] == 28'h0) else $error("pointer upper bits");
	AST_RDZERO: assert property (pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // bdm_core_chk

bind bdm_core bdm_core_chk i_chk (.*);

// ---- bdm_cpu_model.sv ----
`timescale 1ns/10ps
// ==========================================
// Execute stage: one request, then an idle cycle
module bdm_cpu_model (
	input  wire logic  core_clk,
	output logic       ex_valid,
	output logic       ex_write,
	output logic       ex_access_bit,
	output logic       ex_full_addr,
	output logic [11:0] ex_full_src,
	output logic [11:0] ex_full_dst,
	output logic [7:0] ex_operand,
	output logic [7:0] ex_wdata,
	output logic       ex_load_bank,
	output logic [7:0] ex_bank_literal,
	output logic       ex_status_upd,
	output logic [4:0] ex_status_in
);
	// Quiet lines at time zero
	initial begin
		{ex_valid, ex_write, ex_access_bit, ex_full_addr} = '0;
		{ex_full_src, ex_full_dst, ex_operand, ex_wdata} = '0;
		{ex_load_bank, ex_bank_literal, ex_status_upd, ex_status_in} = '0;
	end
	// k = {status, load, full, write, access}; gap covers move write
	task op(input logic [4:0] k, input logic [11:0] a, b,
		input logic [7:0] d);
		@(posedge core_clk);
		{ex_status_upd, ex_load_bank, ex_full_addr, ex_write,
			ex_access_bit} <= k;
		ex_valid <= 1'b1;
		{ex_full_src, ex_operand, ex_full_dst} <= {a, a[7:0], b};
		{ex_wdata, ex_bank_literal, ex_status_in} <= {d, d, d[4:0]};
		@(posedge core_clk);
		ex_valid <= 1'b0;
		ex_operand <= ~a[7:0]; // Stale operand must not look valid
		#1;
	endtask
endmodule // bdm_cpu_model

// ---- banked_data_memory_addressing_tb.sv ----
`timescale 1ns/10ps
module banked_data_memory_addressing_tb;
	import bdm_pkg::*;
	logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic ex_valid, ex_write, ex_access_bit, ex_full_addr, ex_load_bank;
	logic ex_status_upd, ex_rvalid, ex_pc_low_wr, pready, pslverr, se;
	logic [11:0] paddr = 0, ex_full_src, ex_full_dst, ex_addr, ea;
	logic [7:0] ex_operand, ex_wdata, ex_bank_literal, ex_rdata, o, d;
	logic [4:0] ex_status_in, status_flags;
	logic [31:0] pwdata = 0, prdata, r;
	logic [7:0] wo[3] = '{8'h5f, 8'h60, 8'hff};
	int n_fail = 0, checks = 0, mem[int];
	// ==========================================
	// Clock and instances
	always #5 core_clk = ~core_clk;
	bdm_core i_bdm_core (.*);
	bdm_cpu_model i_bdm_cpu_model (.*);
	task chk(input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: saw %h, want %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// APB cycle; access phase held until pready seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int n;
		@(posedge core_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			wrap_up();
		end
		{r, se} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	// Window address from the split point
	function logic [11:0] win(input logic [7:0] op, input logic x);
		win = {(op < (x ? XWIN_SPLIT : WIN_SPLIT)) ? 4'h0 : 4'hf, op};
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hfbb94f64));
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(0, REG_BANK_PTR, 0);
		chk(r, 0);
		apb(1, REG_BANK_PTR, 32'hff);
		apb(0, REG_BANK_PTR, 0);
		chk(r, 32'h0f);
		apb(0, 12'h00c, 0);
		chk(se, 1);
		chk(r, 0);
		// Each bank: literal load with junk upper nibble, write, readback
		for (int b = 0; b < 16; b++) begin
			{o, d} = {8'($urandom) | 8'h01, 8'($urandom)};
			ea = {b[3:0], o};
			i_bdm_cpu_model.op(5'b01000, 0, 0, {4'ha, b[3:0]});
			apb(0, REG_BANK_PTR, 0);
			chk(r, b);
			i_bdm_cpu_model.op(5'b00011, o, 0, d);
			mem[ea] = d;
			chk(ex_addr, ea);
			i_bdm_cpu_model.op(5'b00001, o, 0, 0);
			chk(ex_rdata, mem[ea]);
			chk(ex_rvalid, 1);
		end
		// Window edges and a random offset, read back through banks
		for (int i = 0; i < 4; i++) begin
			o = (i == 3) ? 8'($urandom) | 8'h01 : wo[i];
			d = 8'($urandom);
			ea = win(o, 0);
			i_bdm_cpu_model.op(5'b00010, o, 0, d);
			mem[ea] = d;
			chk(ex_addr, ea);
			i_bdm_cpu_model.op(5'b01000, 0, 0, {4'h0, ea[11:8]});
			i_bdm_cpu_model.op(5'b00001, o, 0, 0);
			chk(ex_rdata, mem[ea]);
		end
		// Full move with the pointer aimed elsewhere
		i_bdm_cpu_model.op(5'b00100, ea, 12'h123, 0);
		mem[12'h123] = mem[ea];
		i_bdm_cpu_model.op(5'b01000, 0, 0, 8'h01);
		i_bdm_cpu_model.op(5'b00001, 12'h023, 0, 0);
		chk(ex_rdata, mem[12'h123]);
		i_bdm_cpu_model.op(5'b01000, 0, 0, 8'h0f);
		i_bdm_cpu_model.op(5'b10011, 8'hf9, 0, 8'h15);
		chk(ex_pc_low_wr, 1);
		chk(status_flags, 5'h15);
		apb(0, REG_STATUS, 0);
		chk(r, 32'h15);
		apb(1, REG_CFG, 1);
		apb(0, REG_CFG, 0);
		chk(r, 1);
		i_bdm_cpu_model.op(5'b00000, 8'h70, 0, 0);
		chk(ex_addr, win(8'h70, 1));
		i_bdm_cpu_model.op(5'b00000, 8'h90, 0, 0);
		chk(ex_addr, win(8'h90, 1));
		wrap_up();
	end
endmodule // banked_data_memory_addressing_tb
